// file: mms_core.sv
// Management, flag, interrupt and power sequencing logic of a module end
`timescale 1ns/1ps
`default_nettype none


module mms_core
   import mms_pkg::*;
#(
   parameter int unsigned INIT_CYCLES = INIT_DELAY,
   parameter int unsigned LP_ENTER_CYCLES = LP_ENTER_DELAY,
   parameter int unsigned LP_EXIT_CYCLES = LP_EXIT_DELAY
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // Register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   // Host side pins
   input wire logic module_reset_n_i,
   input wire logic low_power_or_tx_off_pin_i,
   output logic attention_or_signal_lost_pin_o,
   // Conditions from the module
   input wire logic rx_los_i,
   input wire logic tx_fault_i,
   input wire logic other_fault_i,
   // Status outputs
   output logic irq_o,
   output logic tx_disable_o,
   output logic low_power_o,
   output logic fully_functional_o,
   output logic bus_ready_o
);

   // ****************************************
   // State
   // ****************************************
   typedef enum logic {
      INIT_BUSY,
      INIT_DONE
   } mms_init_t;

   typedef enum logic [1:0] {
      PW_FULL,
      PW_ENTER,
      PW_LOW,
      PW_EXIT
   } mms_pw_t;

   typedef struct packed {
      mms_init_t init_st;
      logic [31:0] init_cnt;
      mms_pw_t pw_st;
      logic [31:0] pw_cnt;
      logic [NFLAG-1:0] flags;
      logic [NFLAG-1:0] mask;
      logic [2:0] ctrl;
      logic [DATA_W-1:0] rdata;
      logic pin_out;
      logic irq;
      logic tx_disable;
      logic low_power;
      logic functional;
      logic bus_ready;
   } mms_state_t;

   localparam mms_state_t STATE_RST = '{
      init_st: INIT_BUSY,
      init_cnt: 32'h0000_0000,
      pw_st: PW_FULL,
      pw_cnt: 32'h0000_0000,
      flags: FLAGS_RST,
      mask: MASK_RST,
      ctrl: CTRL_RST,
      rdata: 32'h0000_0000,
      pin_out: 1'b1,
      irq: 1'b0,
      tx_disable: 1'b0,
      low_power: 1'b0,
      functional: 1'b0,
      bus_ready: 1'b0
   };

   mms_state_t s_q;
   mms_state_t s_d;

   // ****************************************
   // Next state
   // ****************************************
   logic [NFLAG-1:0] events;
   logic [NFLAG-1:0] pending;
   logic lp_req;
   logic flag_rd;
   logic init_end;
   logic [DATA_W-1:0] status_word;

   always_comb begin
      s_d = s_q;
      events = '0;
      pending = '0;
      lp_req = 1'b0;
      flag_rd = 1'b0;
      init_end = 1'b0;
      status_word = '0;

      // Init sequencing; a low reset pin restarts the whole module
      unique case (s_q.init_st)
         INIT_BUSY: begin
            if (s_q.init_cnt >= INIT_CYCLES - 1) begin
               s_d.init_st = INIT_DONE;
               init_end = 1'b1;
            end else begin
               s_d.init_cnt = s_q.init_cnt + 32'h0000_0001;
            end
         end
         INIT_DONE: begin
            s_d.init_cnt = s_q.init_cnt;
         end
      endcase

      // Conditions are levels; a flag re-arms while its cause persists
      events[FLG_RX_LOS] = rx_los_i;
      events[FLG_TX_FAULT] = tx_fault_i;
      events[FLG_OTHER] = other_fault_i;
      events[FLG_DATA_READY] = init_end;

      // Register port
      flag_rd = rd_i && (addr_i == OFS_FLAGS);
      status_word[STS_DATA_NOT_READY] = (s_q.init_st == INIT_BUSY);
      status_word[STS_INIT_BUSY] = (s_q.init_st == INIT_BUSY);
      status_word[STS_LOW_POWER] = s_q.low_power;
      status_word[STS_FUNCTIONAL] = s_q.functional;
      status_word[STS_TX_DISABLED] = s_q.tx_disable;
      s_d.rdata = '0;
      if (rd_i) begin
         unique case (addr_i)
            OFS_FLAGS: s_d.rdata[NFLAG-1:0] = s_q.flags;
            OFS_MASK: s_d.rdata[NFLAG-1:0] = s_q.mask;
            OFS_CTRL: s_d.rdata[2:0] = s_q.ctrl;
            OFS_STATUS: s_d.rdata = status_word;
            default: s_d.rdata = '0;
         endcase
      end
      if (wr_i) begin
         unique case (addr_i)
            OFS_MASK: s_d.mask = wdata_i[NFLAG-1:0];
            OFS_CTRL: s_d.ctrl = wdata_i[2:0];
            default: s_d.mask = s_q.mask;
         endcase
      end

      // Sticky flags, cleared by the read that returns them; set wins
      s_d.flags = (s_q.flags & ~{NFLAG{flag_rd}}) | events;

      // Power request from the pin (in low-power mode) or override bit
      lp_req = (!s_q.ctrl[CTL_LP_PIN_TRANSMIT_DISABLE_FUNCTION] && low_power_or_tx_off_pin_i)
               || s_q.ctrl[CTL_POWER_OVERRIDE];
      unique case (s_q.pw_st)
         PW_FULL: begin
            if (lp_req) begin
               s_d.pw_st = PW_ENTER;
               s_d.pw_cnt = '0;
            end
         end
         PW_ENTER: begin
            s_d.pw_cnt = s_q.pw_cnt + 32'h0000_0001;
            if (!lp_req) begin
               s_d.pw_st = PW_EXIT;
               s_d.pw_cnt = '0;
            end else if (s_q.pw_cnt >= LP_ENTER_CYCLES - 1) begin
               s_d.pw_st = PW_LOW;
            end
         end
         PW_LOW: begin
            if (!lp_req) begin
               s_d.pw_st = PW_EXIT;
               s_d.pw_cnt = '0;
            end
         end
         PW_EXIT: begin
            s_d.pw_cnt = s_q.pw_cnt + 32'h0000_0001;
            if (lp_req) begin
               s_d.pw_st = PW_ENTER;
               s_d.pw_cnt = '0;
            end else if (s_q.pw_cnt >= LP_EXIT_CYCLES - 1) begin
               s_d.pw_st = PW_FULL;
            end
         end
      endcase

      // Outputs; a mask write reaches irq two cycles after the write
      pending = s_q.flags & ~s_q.mask;
      s_d.irq = |pending;
      s_d.pin_out = s_q.ctrl[CTL_ATTN_PIN_LOS] ? !rx_los_i
                                               : !(|pending);
      s_d.tx_disable = s_q.ctrl[CTL_LP_PIN_TRANSMIT_DISABLE_FUNCTION]
                       && low_power_or_tx_off_pin_i;
      s_d.low_power = (s_q.pw_st == PW_LOW) || (s_q.pw_st == PW_ENTER
                       && s_q.pw_cnt >= LP_ENTER_CYCLES - 1);
      s_d.functional = (s_q.init_st == INIT_DONE)
                       && (s_q.pw_st == PW_FULL);
      // The register port answers even during init
      s_d.bus_ready = 1'b1;

      // Pin reset: any low sample restarts; host keeps it long enough
      if (!module_reset_n_i) begin
         s_d = STATE_RST;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_o = s_q.rdata;
   assign attention_or_signal_lost_pin_o = s_q.pin_out;
   assign irq_o = s_q.irq;
   assign tx_disable_o = s_q.tx_disable;
   assign low_power_o = s_q.low_power;
   assign fully_functional_o = s_q.functional;
   assign bus_ready_o = s_q.bus_ready;

endmodule

`default_nettype wire

// file: mms_pkg.sv
// Constants, register map and timing counts for the module management block
package mms_pkg;

   // ****************************************
   // Clock and time conversion
   // ****************************************
   localparam int unsigned CLK_KHZ = 125_000;

   function automatic int unsigned mms_ms_cycles(input int unsigned ms);
      mms_ms_cycles = ms * CLK_KHZ;
   endfunction

   function automatic int unsigned mms_us_cycles(input int unsigned us);
      mms_us_cycles = (us * CLK_KHZ) / 1000;
   endfunction

   // ****************************************
   // Deadlines as printed
   // ****************************************
   localparam int unsigned INIT_MS = 2000;
   localparam int unsigned RESET_MIN_US = 10;
   localparam int unsigned ATTN_ON_MS = 200;
   localparam int unsigned ATTN_OFF_US = 500;
   localparam int unsigned LOS_ON_MS = 100;
   localparam int unsigned FLAG_ON_MS = 200;
   localparam int unsigned MASK_MS = 100;
   localparam int unsigned MODE_CHANGE_MS = 100;
   localparam int unsigned LP_ENTER_MS = 100;
   localparam int unsigned LP_EXIT_MS = 300;

   // Longest times (shortest for reset) in cycles, rounded down
   localparam int unsigned INIT_MAX_CYCLES = mms_ms_cycles(INIT_MS);
   localparam int unsigned RESET_MIN_CYCLES = mms_us_cycles(RESET_MIN_US);
   localparam int unsigned LP_ENTER_MAX_CYCLES = mms_ms_cycles(LP_ENTER_MS);
   localparam int unsigned LP_EXIT_MAX_CYCLES = mms_ms_cycles(LP_EXIT_MS);

   // Counts actually used; two cycles of margin for the output flops
   localparam int unsigned INIT_DELAY = INIT_MAX_CYCLES - 2;
   localparam int unsigned LP_ENTER_DELAY = LP_ENTER_MAX_CYCLES - 2;
   localparam int unsigned LP_EXIT_DELAY = LP_EXIT_MAX_CYCLES - 2;

   // ****************************************
   // Register map
   // ****************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFS_FLAGS = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h04;
   localparam logic [7:0] OFS_CTRL = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;

   // Flag and mask layout
   localparam int NFLAG = 4;
   localparam int FLG_RX_LOS = 0;
   localparam int FLG_TX_FAULT = 1;
   localparam int FLG_OTHER = 2;
   localparam int FLG_DATA_READY = 3;

   // Control layout
   localparam int CTL_POWER_OVERRIDE = 0;
   localparam int CTL_LP_PIN_TRANSMIT_DISABLE_FUNCTION = 1;
   localparam int CTL_ATTN_PIN_LOS = 2;

   // Status layout
   localparam int STS_DATA_NOT_READY = 0;
   localparam int STS_INIT_BUSY = 1;
   localparam int STS_LOW_POWER = 2;
   localparam int STS_FUNCTIONAL = 3;
   localparam int STS_TX_DISABLED = 4;

   // Reset values
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [3:0] MASK_RST = 4'h0;
   localparam logic [2:0] CTRL_RST = 3'h0;

endpackage

// file: mms_core_sva.sv
// Port-level assertion checker for the management block
`timescale 1ns/1ps
`default_nettype none
module mms_core_sva
   import mms_pkg::*;
#(
   parameter int unsigned INIT_CYCLES = 20,
   parameter int unsigned LP_ENTER_CYCLES = 5,
   parameter int unsigned LP_EXIT_CYCLES = 10
) (
   // Clock, reset and register port
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DATA_W-1:0] rdata_o,
   // Pins, conditions and status
   input wire logic module_reset_n_i,
   input wire logic low_power_or_tx_off_pin_i,
   input wire logic attention_or_signal_lost_pin_o,
   input wire logic rx_los_i,
   input wire logic tx_fault_i,
   input wire logic other_fault_i,
   input wire logic irq_o,
   input wire logic tx_disable_o,
   input wire logic low_power_o,
   input wire logic fully_functional_o,
   input wire logic bus_ready_o
);
   localparam int INIT_LIM = INIT_CYCLES + 3;
   logic [3:0] msk_q;
   logic [2:0] ctl_q;
   logic nc;
   assign nc = !rx_los_i && !tx_fault_i && !other_fault_i;
   // Shadow copies, since the checker sees only the ports
   always_ff @(posedge core_clk_i) begin
      if (reset_i || !module_reset_n_i) begin
         msk_q <= '0;
         ctl_q <= '0;
      end else if (wr_i && addr_i == OFS_MASK) begin
         msk_q <= wdata_i[3:0];
      end else if (wr_i && addr_i == OFS_CTRL) begin
         ctl_q <= wdata_i[2:0];
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i || !module_reset_n_i);
   a_los_irq: assert property (rx_los_i && !msk_q[0] |-> ##[1:2] irq_o)
      else $error("no irq after signal loss");
   a_fault_irq: assert property (tx_fault_i && !msk_q[1] |-> ##[1:2] irq_o)
      else $error("no irq after tx fault");
   a_attn_mirror: assert property (!$past(ctl_q[2]) |->
      attention_or_signal_lost_pin_o == !irq_o) else $error("attention pin");
   a_los_pin: assert property ($past(ctl_q[2]) |->
      attention_or_signal_lost_pin_o == !$past(rx_los_i)) else $error("los pin");
   a_transmit_disable_function: assert property (tx_disable_o ==
      ($past(ctl_q[1]) && $past(low_power_or_tx_off_pin_i)))
      else $error("tx off");
   a_read_clears: assert property (rd_i && addr_i == OFS_FLAGS && nc
      ##1 nc[*2] |-> !irq_o) else $error("irq kept after read");
   a_lp_nofunc: assert property (low_power_o |-> !fully_functional_o)
      else $error("functional in low power");
   a_init_time: assert property ($fell(reset_i) && !low_power_or_tx_off_pin_i
      |-> ##[1:INIT_LIM] fully_functional_o) else $error("init late");
   cover property (rd_i && addr_i == OFS_FLAGS && irq_o);
   cover property (low_power_o);
   cover property (tx_disable_o);
endmodule
bind mms_core mms_core_sva #(.INIT_CYCLES(INIT_CYCLES),
   .LP_ENTER_CYCLES(LP_ENTER_CYCLES), .LP_EXIT_CYCLES(LP_EXIT_CYCLES))
   u_mms_core_sva (.*);
`default_nettype wire

// file: mms_host_model.sv
// Host controller model driving the reset and low-power pins
`timescale 1ns/1ps
`default_nettype none
module mms_host_model
   import mms_pkg::*;
#(
   parameter int unsigned HOLD = RESET_MIN_CYCLES
) (
   // Clock and commands
   input wire logic core_clk_i,
   input wire logic pulse_i,
   input wire logic lp_i,
   // Pins towards the module
   output logic module_reset_n_o,
   output logic low_power_pin_o
);
   int unsigned cnt_q = 0;
   initial begin
      module_reset_n_o = 1'b1;
      low_power_pin_o = 1'b0;
   end
   // Reset held the full minimum so the module reset is guaranteed
   always @(posedge core_clk_i) begin
      low_power_pin_o <= lp_i;
      if (pulse_i) cnt_q <= HOLD;
      else if (cnt_q != 0) cnt_q <= cnt_q - 1;
      module_reset_n_o <= !(pulse_i || cnt_q > 1);
   end
endmodule
`default_nettype wire

// file: mms_core_tb.sv
// Self-checking testbench of the management block
`timescale 1ns/1ps
`default_nettype none
module mms_core_tb
   import mms_pkg::*;
;
   localparam int INI = 20;
   localparam int LPE = 5;
   localparam int LPX = 10;
   logic core_clk_i, reset_i = 1, wr_i = 0, rd_i = 0, pls = 0, lp = 0;
   logic rx_los_i = 0, tx_fault_i = 0, other_fault_i = 0;
   logic [7:0] addr_i = '0;
   logic [31:0] wdata_i = '0, rdata_o;
   logic module_reset_n_i, low_power_or_tx_off_pin_i;
   logic attention_or_signal_lost_pin_o, irq_o, tx_disable_o;
   logic low_power_o, fully_functional_o, bus_ready_o;
   int fail_count = 0;
   int num_checks = 0;
   mms_core #(.INIT_CYCLES(INI), .LP_ENTER_CYCLES(LPE),
      .LP_EXIT_CYCLES(LPX)) u_mms_core (.*);
   mms_host_model u_mms_host_model (.core_clk_i(core_clk_i), .pulse_i(pls),
      .lp_i(lp), .module_reset_n_o(module_reset_n_i),
      .low_power_pin_o(low_power_or_tx_off_pin_i));
   initial begin
      core_clk_i = 0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   task automatic chk(input string n, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      wr_i <= w;
      rd_i <= !w;
      addr_i <= a;
      wdata_i <= d;
      @(posedge core_clk_i);
      wr_i <= 0;
      rd_i <= 0;
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      acc(0, a, '0);
      #1 chk(n, e, rdata_o);
   endtask
   task automatic cond(input logic [2:0] c);
      @(posedge core_clk_i);
      {other_fault_i, tx_fault_i, rx_los_i} <= c;
      @(posedge core_clk_i);
      {other_fault_i, tx_fault_i, rx_los_i} <= 3'h0;
   endtask
   task automatic t_init;
      cyc(INI + 4);
      chk("bus_ready", 1, bus_ready_o);
      chk("functional", 1, fully_functional_o);
      chk("irq", 1, irq_o);
      rdc("status", OFS_STATUS, 32'h0000_0008);
      rdc("flags", OFS_FLAGS, 32'h0000_0008);
      cyc(2);
      chk("irq", 0, irq_o);
      $display("init test done");
   endtask
   task automatic t_flags;
      for (int i = 0; i < 3; i++) begin
         cond(3'h1 << i);
         cyc(3);
         chk("irq", 1, irq_o);
         chk("attn pin", 0, attention_or_signal_lost_pin_o);
         rdc("flags", OFS_FLAGS, 32'h0000_0001 << i);
         cyc(2);
         chk("attn pin", 1, attention_or_signal_lost_pin_o);
      end
      $display("flag test done");
   endtask
   task automatic t_mask;
      acc(1, OFS_MASK, 32'h0000_0001);
      rdc("mask", OFS_MASK, 32'h0000_0001);
      cond(3'h1);
      cyc(3);
      chk("masked irq", 0, irq_o);
      acc(1, OFS_MASK, 32'h0000_0000);
      cyc(2);
      chk("unmasked irq", 1, irq_o);
      rdc("flags", OFS_FLAGS, 32'h0000_0001);
      rdc("unmapped", 8'h10, 32'h0000_0000);
      $display("mask test done");
   endtask
   task automatic t_power;
      @(posedge core_clk_i);
      lp <= 1;
      cyc(LPE + 5);
      chk("low power", 1, low_power_o);
      @(posedge core_clk_i);
      lp <= 0;
      cyc(LPX + 6);
      chk("functional", 1, fully_functional_o);
      acc(1, OFS_CTRL, 32'h0000_0001);
      cyc(LPE + 5);
      chk("override", 1, low_power_o);
      acc(1, OFS_CTRL, 32'h0000_0006);
      cyc(LPX + 6);
      chk("functional", 1, fully_functional_o);
      @(posedge core_clk_i);
      lp <= 1;
      cyc(3);
      chk("tx off", 1, tx_disable_o);
      chk("low power", 0, low_power_o);
      @(posedge core_clk_i);
      rx_los_i <= 1;
      cyc(2);
      chk("los pin", 0, attention_or_signal_lost_pin_o);
      @(posedge core_clk_i);
      rx_los_i <= 0;
      lp <= 0;
      $display("power test done");
   endtask
   task automatic t_reset;
      @(posedge core_clk_i);
      pls <= 1;
      @(posedge core_clk_i);
      pls <= 0;
      cyc(3);
      chk("functional", 0, fully_functional_o);
      cyc(RESET_MIN_CYCLES + INI + 4);
      chk("functional", 1, fully_functional_o);
      rdc("flags", OFS_FLAGS, 32'h0000_0008);
      $display("reset test done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge core_clk_i);
      reset_i <= 0;
      t_init;
      t_flags;
      t_mask;
      t_power;
      t_reset;
      wrap_up;
   end
   initial begin
      #50_000;
      fail_count++;
      wrap_up;
   end
endmodule
`default_nettype wire
